// file: design/ssft_pkg.sv
package ssft_pkg;
  // System clock doubles as the sensor master clock
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Start-up waits, in their own units
  localparam int unsigned T_RESET_HOLD_NS = 1000;
  localparam int unsigned T_POST_RESET_NS = 1000;
  localparam int unsigned T_SETTLE_TYP_MS = 5;
  localparam int unsigned T_SETTLE_MAX_MS = 20;
  localparam int unsigned RESET_HOLD_CYC = (T_RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned POST_RESET_CYC = (T_POST_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_TYP_CYC = (T_SETTLE_TYP_MS * 1000000 / CLK_PERIOD_PS) * 1000;
  localparam int unsigned SETTLE_MAX_CYC = (T_SETTLE_MAX_MS * 1000000 / CLK_PERIOD_PS) * 1000;
  // Serial bit clock ratios
  localparam logic [3:0] RATIO_10BIT = 4'ha;
  localparam logic [3:0] RATIO_12BIT = 4'hc;
  // Timing formula constants
  localparam logic [7:0] CYC_PER_UNIT = 8'h81;
  localparam logic [2:0] OUT_CODE_MAX = 3'h4;
  localparam logic [5:0] FOT_FIXED = 6'h02;
  // Sensor register addresses
  localparam logic [6:0] ADR_LINES_LO = 7'h01;
  localparam logic [6:0] ADR_LINES_HI = 7'h02;
  localparam logic [6:0] ADR_EXP_LO = 7'h2a;
  localparam logic [6:0] ADR_EXP_MID = 7'h2b;
  localparam logic [6:0] ADR_EXP_HI = 7'h2c;
  localparam logic [6:0] ADR_FRAMES_LO = 7'h46;
  localparam logic [6:0] ADR_FRAMES_HI = 7'h47;
  localparam logic [6:0] ADR_OUT_CODE = 7'h48;
  localparam logic [6:0] ADR_FOT_LEN = 7'h49;
  localparam logic [6:0] ADR_BIT_MODE = 7'h4a;
  localparam logic [6:0] ADR_GAIN = 7'h50;
  // Sensor register reset values
  localparam logic [15:0] RST_LINES = 16'h0440;
  localparam logic [23:0] RST_EXP = 24'h000400;
  localparam logic [15:0] RST_FRAMES = 16'h0001;
  localparam logic [2:0] RST_OUT_CODE = 3'h4;
  localparam logic [7:0] RST_FOT_LEN = 8'h0a;
  localparam logic [7:0] RST_GAIN = 8'h20;
  // Controller register map
  localparam logic [3:0] CREG_CTRL = 4'h0;
  localparam logic [3:0] CREG_UPLOAD = 4'h1;
  localparam logic [3:0] CREG_FRAME = 4'h2;
  localparam logic [3:0] CREG_STATUS = 4'h3;
  localparam int unsigned CTRL_UPLOAD_MODE = 0;
  localparam int unsigned CTRL_MODE12 = 1;
  localparam int unsigned CTRL_MAX_GAIN = 2;
  localparam int unsigned CTRL_UPLOAD_DONE = 3;
  localparam int unsigned CTRL_RESTART = 4;
  localparam int unsigned STAT_READY = 3;
  localparam int unsigned STAT_BUSY = 4;
  localparam int unsigned STAT_REFUSED = 5;
endpackage

// file: design/ssft_link_if.sv
`timescale 1ns/1ps
interface ssft_link_if;
  logic master_clk_run;
  logic [3:0] bit_clk_ratio;
  logic system_reset_low;
  logic frame_request;
  logic upload_valid;
  logic [6:0] upload_addr;
  logic [7:0] upload_data;
  logic dev_exposing;
  logic dev_fot;
  logic dev_readout;
  logic dev_busy;
  logic frame_done;
  modport dev (
    input master_clk_run,
    input bit_clk_ratio,
    input system_reset_low,
    input frame_request,
    input upload_valid,
    input upload_addr,
    input upload_data,
    output dev_exposing,
    output dev_fot,
    output dev_readout,
    output dev_busy,
    output frame_done
  );
  modport ctl (
    output master_clk_run,
    output bit_clk_ratio,
    output system_reset_low,
    output frame_request,
    output upload_valid,
    output upload_addr,
    output upload_data,
    input dev_exposing,
    input dev_fot,
    input dev_readout,
    input dev_busy,
    input frame_done
  );
endinterface

// file: design/ssft_sensor.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
module ssft_sensor
  import ssft_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  ssft_link_if.dev link,
  output logic [7:0] gain_setting,
  output logic [7:0] fot_length,
  output logic bit_mode_12,
  output logic [15:0] frames_sent,
  output logic [31:0] frame_period_cyc
);

  typedef enum {
    SS_IDLE,
    SS_EXPOSE,
    SS_FOT,
    SS_READ,
    SS_WAIT_EXP
  } ssft_seq_t;

  typedef struct packed {
    logic [1:0] rstl_sync;
    logic [1:0] req_sync;
    logic req_prev;
    logic [1:0] upl_sync;
    logic [1:0][14:0] upl_word;
    logic [15:0] lines;
    logic [23:0] exposure;
    logic [15:0] frames;
    logic [2:0] out_code;
    logic [7:0] fot_len;
    logic mode12;
    logic [7:0] gain;
    ssft_seq_t seq;
    logic [31:0] cnt;
    logic [23:0] exp_cnt;
    logic exp_on;
    logic exp_ready;
    logic [15:0] left;
    logic done;
    logic [15:0] sent;
    logic [31:0] period_cnt;
    logic [31:0] period;
  } ssft_dev_state_t;

  ssft_dev_state_t state_reg;
  ssft_dev_state_t state_next;
  logic [4:0] per_output;
  logic [15:0] line_base;
  logic [15:0] line_cyc;
  logic [31:0] fot_cyc;
  logic [31:0] ro_cyc;
  logic req_rise;
  logic [23:0] exp_load;

  // Cycle budgets of one frame, in master clock periods
  always_comb
  begin
    per_output = 5'h01 << (OUT_CODE_MAX - state_reg.out_code);
    line_base = 16'(CYC_PER_UNIT) * 16'(per_output);
    // 12-bit conversion stretches each line by 12/10
    if (state_reg.mode12)
    begin
      line_cyc = 16'((32'(line_base) * 32'(RATIO_12BIT)) / 32'(RATIO_10BIT));
    end
    else
    begin
      line_cyc = line_base;
    end
    fot_cyc = (32'(state_reg.fot_len) + 32'(FOT_FIXED) * 32'(per_output))
      * 32'(CYC_PER_UNIT);
    ro_cyc = 32'(line_cyc) * 32'(state_reg.lines);
    req_rise = state_reg.req_sync[1] && !state_reg.req_prev;
    exp_load = (state_reg.exposure == 24'h000000) ? 24'h000001 : state_reg.exposure;
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.rstl_sync = {state_reg.rstl_sync[0], link.system_reset_low};
    state_next.req_sync = {state_reg.req_sync[0], link.frame_request};
    state_next.req_prev = state_reg.req_sync[1];
    state_next.upl_sync = {state_reg.upl_sync[0], link.upload_valid};
    state_next.upl_word = {state_reg.upl_word[0], link.upload_addr, link.upload_data};
    state_next.done = 1'b0;
    if (state_reg.seq != SS_IDLE)
    begin
      state_next.period_cnt = state_reg.period_cnt + 32'h00000001;
    end
    // Exposure timer runs beside the read-out of the previous frame
    if (state_reg.exp_on)
    begin
      if (state_reg.exp_cnt <= 24'h000001)
      begin
        state_next.exp_on = 1'b0;
        state_next.exp_ready = 1'b1;
      end
      else
      begin
        state_next.exp_cnt = state_reg.exp_cnt - 24'h000001;
      end
    end
    case (state_reg.seq)
      SS_IDLE:
      begin
        // Request while busy is ignored by leaving this state only here
        if (req_rise && state_reg.frames != 16'h0000)
        begin
          state_next.left = state_reg.frames;
          state_next.exp_cnt = exp_load;
          state_next.exp_on = 1'b1;
          state_next.exp_ready = 1'b0;
          state_next.period_cnt = 32'h00000000;
          state_next.seq = SS_EXPOSE;
        end
      end
      SS_EXPOSE, SS_WAIT_EXP:
      begin
        // Long exposure holds off the next overhead interval
        if (state_reg.exp_ready)
        begin
          state_next.exp_ready = 1'b0;
          state_next.cnt = fot_cyc - 32'h00000001;
          state_next.seq = SS_FOT;
        end
      end
      SS_FOT:
      begin
        if (state_reg.cnt == 32'h00000000)
        begin
          state_next.cnt = ro_cyc - 32'h00000001;
          state_next.seq = SS_READ;
          state_next.left = state_reg.left - 16'h0001;
          if (state_reg.left != 16'h0001)
          begin
            state_next.exp_cnt = exp_load;
            state_next.exp_on = 1'b1;
          end
        end
        else
        begin
          state_next.cnt = state_reg.cnt - 32'h00000001;
        end
      end
      SS_READ:
      begin
        if (state_reg.cnt == 32'h00000000)
        begin
          state_next.done = 1'b1;
          state_next.sent = state_reg.sent + 16'h0001;
          state_next.period = state_reg.period_cnt + 32'h00000001;
          state_next.period_cnt = 32'h00000000;
          if (state_reg.left == 16'h0000)
          begin
            state_next.seq = SS_IDLE;
          end
          else if (state_reg.exp_ready || (state_reg.exp_on && state_reg.exp_cnt <= 24'h000001))
          begin
            // Short exposure: next overhead follows the read-out at once
            state_next.exp_ready = 1'b0;
            state_next.exp_on = 1'b0;
            state_next.cnt = fot_cyc - 32'h00000001;
            state_next.seq = SS_FOT;
          end
          else
          begin
            state_next.seq = SS_WAIT_EXP;
          end
        end
        else
        begin
          state_next.cnt = state_reg.cnt - 32'h00000001;
        end
      end
      default:
      begin
        state_next.seq = SS_IDLE;
      end
    endcase
    // Register upload from the controller
    if (state_reg.upl_sync[1])
    begin
      case (state_reg.upl_word[1][14:8])
        ADR_LINES_LO: state_next.lines[7:0] = state_reg.upl_word[1][7:0];
        ADR_LINES_HI: state_next.lines[15:8] = state_reg.upl_word[1][7:0];
        ADR_EXP_LO: state_next.exposure[7:0] = state_reg.upl_word[1][7:0];
        ADR_EXP_MID: state_next.exposure[15:8] = state_reg.upl_word[1][7:0];
        ADR_EXP_HI: state_next.exposure[23:16] = state_reg.upl_word[1][7:0];
        ADR_FRAMES_LO: state_next.frames[7:0] = state_reg.upl_word[1][7:0];
        ADR_FRAMES_HI: state_next.frames[15:8] = state_reg.upl_word[1][7:0];
        ADR_OUT_CODE:
        begin
          if (state_reg.upl_word[1][7:0] <= {5'h00, OUT_CODE_MAX})
          begin
            state_next.out_code = state_reg.upl_word[1][2:0];
          end
        end
        ADR_FOT_LEN: state_next.fot_len = state_reg.upl_word[1][7:0];
        ADR_BIT_MODE: state_next.mode12 = state_reg.upl_word[1][0];
        ADR_GAIN: state_next.gain = state_reg.upl_word[1][7:0];
        default: state_next.gain = state_next.gain;
      endcase
    end
    // Low system reset restores defaults and parks the sequencer
    if (!state_reg.rstl_sync[1])
    begin
      state_next.lines = RST_LINES;
      state_next.exposure = RST_EXP;
      state_next.frames = RST_FRAMES;
      state_next.out_code = RST_OUT_CODE;
      state_next.fot_len = RST_FOT_LEN;
      state_next.mode12 = 1'b0;
      state_next.gain = RST_GAIN;
      state_next.seq = SS_IDLE;
      state_next.cnt = 32'h00000000;
      state_next.exp_cnt = 24'h000000;
      state_next.exp_on = 1'b0;
      state_next.exp_ready = 1'b0;
      state_next.left = 16'h0000;
      state_next.done = 1'b0;
      state_next.sent = 16'h0000;
      state_next.period_cnt = 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '{
        rstl_sync: 2'h0, req_sync: 2'h0, req_prev: 1'b0, upl_sync: 2'h0,
        lines: RST_LINES, exposure: RST_EXP, frames: RST_FRAMES,
        out_code: RST_OUT_CODE, fot_len: RST_FOT_LEN, mode12: 1'b0,
        gain: RST_GAIN, seq: SS_IDLE, cnt: 32'h00000000, exp_cnt: 24'h000000,
        exp_on: 1'b0, exp_ready: 1'b0, left: 16'h0000, done: 1'b0, upl_word: 30'h00000000,
        sent: 16'h0000, period_cnt: 32'h00000000, period: 32'h00000000};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign link.dev_exposing = state_reg.exp_on;
  assign link.dev_fot = (state_reg.seq == SS_FOT);
  assign link.dev_readout = (state_reg.seq == SS_READ);
  assign link.dev_busy = (state_reg.seq != SS_IDLE);
  assign link.frame_done = state_reg.done;
  assign gain_setting = state_reg.gain;
  assign fot_length = state_reg.fot_len;
  assign bit_mode_12 = state_reg.mode12;
  assign frames_sent = state_reg.sent;
  assign frame_period_cyc = state_reg.period;

endmodule

// file: design/ssft_controller.sv
`timescale 1ns/1ps
module ssft_controller
  import ssft_pkg::*;
#(
  parameter int unsigned SETTLE_TYP = SETTLE_TYP_CYC,
  parameter int unsigned SETTLE_MAX = SETTLE_MAX_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supplies_ok,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  ssft_link_if.ctl link
);

  typedef enum {
    SC_OFF,
    SC_RST_HOLD,
    SC_POST,
    SC_UPLOAD,
    SC_SETTLE,
    SC_READY
  } ssft_phase_t;

  typedef struct packed {
    logic [1:0] sup_sync;
    ssft_phase_t phase;
    logic [31:0] cnt;
    logic upload_mode;
    logic mode12;
    logic max_gain;
    logic upl_valid;
    logic [6:0] upl_addr;
    logic [7:0] upl_data;
    logic req;
    logic refused;
    logic [15:0] rdata;
  } ssft_ctl_state_t;

  ssft_ctl_state_t state_reg;
  ssft_ctl_state_t state_next;
  logic [2:0] phase_code;

  always_comb
  begin
    case (state_reg.phase)
      SC_OFF: phase_code = 3'h0;
      SC_RST_HOLD: phase_code = 3'h1;
      SC_POST: phase_code = 3'h2;
      SC_UPLOAD: phase_code = 3'h3;
      SC_SETTLE: phase_code = 3'h4;
      SC_READY: phase_code = 3'h5;
      default: phase_code = 3'h7;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.sup_sync = {state_reg.sup_sync[0], supplies_ok};
    state_next.upl_valid = 1'b0;
    state_next.req = 1'b0;
    state_next.rdata = 16'h0000;
    if (state_reg.cnt != 32'h00000000)
    begin
      state_next.cnt = state_reg.cnt - 32'h00000001;
    end
    case (state_reg.phase)
      SC_OFF:
      begin
        if (state_reg.sup_sync[1])
        begin
          state_next.cnt = 32'(RESET_HOLD_CYC) - 32'h00000001;
          state_next.phase = SC_RST_HOLD;
        end
      end
      SC_RST_HOLD:
      begin
        if (state_reg.cnt == 32'h00000000)
        begin
          state_next.cnt = 32'(POST_RESET_CYC) - 32'h00000001;
          state_next.phase = SC_POST;
        end
      end
      SC_POST:
      begin
        if (state_reg.cnt == 32'h00000000)
        begin
          state_next.phase = state_reg.upload_mode ? SC_UPLOAD : SC_READY;
        end
      end
      SC_UPLOAD:
      begin
        if (reg_wr && reg_addr == CREG_UPLOAD)
        begin
          state_next.upl_valid = 1'b1;
          state_next.upl_addr = reg_wdata[14:8];
          state_next.upl_data = reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == CREG_CTRL && reg_wdata[CTRL_UPLOAD_DONE])
        begin
          state_next.cnt = (state_reg.max_gain ? SETTLE_MAX : SETTLE_TYP) - 32'h00000001;
          state_next.phase = SC_SETTLE;
        end
      end
      SC_SETTLE:
      begin
        if (state_reg.cnt == 32'h00000000)
        begin
          state_next.phase = SC_READY;
        end
      end
      SC_READY:
      begin
        if (state_reg.sup_sync[1] == 1'b0)
        begin
          state_next.phase = SC_OFF;
        end
      end
      default:
      begin
        state_next.phase = SC_OFF;
      end
    endcase
    if (reg_wr && reg_addr == CREG_FRAME)
    begin
      // Requests outside the ready phase are dropped and flagged
      if (state_reg.phase == SC_READY)
      begin
        state_next.req = 1'b1;
      end
      else
      begin
        state_next.refused = 1'b1;
      end
    end
    if (reg_wr && reg_addr == CREG_CTRL)
    begin
      state_next.upload_mode = reg_wdata[CTRL_UPLOAD_MODE];
      state_next.mode12 = reg_wdata[CTRL_MODE12];
      state_next.max_gain = reg_wdata[CTRL_MAX_GAIN];
      if (reg_wdata[CTRL_RESTART] && state_reg.phase != SC_OFF)
      begin
        state_next.cnt = 32'(RESET_HOLD_CYC) - 32'h00000001;
        state_next.phase = SC_RST_HOLD;
      end
    end
    if (reg_rd)
    begin
      case (reg_addr)
        CREG_CTRL:
        begin
          state_next.rdata = {13'h0000, state_reg.max_gain, state_reg.mode12,
            state_reg.upload_mode};
        end
        CREG_UPLOAD: state_next.rdata = {1'b0, state_reg.upl_addr, state_reg.upl_data};
        CREG_STATUS:
        begin
          state_next.rdata = {10'h000, state_reg.refused, link.dev_busy,
            state_reg.phase == SC_READY, phase_code};
          // Refused flag clears on read unless a new refusal lands now
          if (!(reg_wr && reg_addr == CREG_FRAME && state_reg.phase != SC_READY))
          begin
            state_next.refused = 1'b0;
          end
        end
        default: state_next.rdata = 16'h0000;
      endcase
    end
    if (!state_reg.sup_sync[1])
    begin
      state_next.phase = SC_OFF;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '{
        sup_sync: 2'h0, phase: SC_OFF, cnt: 32'h00000000, upload_mode: 1'b0,
        mode12: 1'b0, max_gain: 1'b0, upl_valid: 1'b0, upl_addr: 7'h00,
        upl_data: 8'h00, req: 1'b0, refused: 1'b0, rdata: 16'h0000};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign link.master_clk_run = (state_reg.phase != SC_OFF);
  assign link.bit_clk_ratio = state_reg.mode12 ? RATIO_12BIT : RATIO_10BIT;
  assign link.system_reset_low = (state_reg.phase != SC_OFF)
    && (state_reg.phase != SC_RST_HOLD);
  assign link.frame_request = state_reg.req;
  assign link.upload_valid = state_reg.upl_valid;
  assign link.upload_addr = state_reg.upl_addr;
  assign link.upload_data = state_reg.upl_data;
  assign reg_rdata = state_reg.rdata;

endmodule

// file: test/ssft_monitor.sv
`timescale 1ns/1ps
module ssft_monitor
  import ssft_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic master_clk_run,
  input wire logic [3:0] bit_clk_ratio,
  input wire logic system_reset_low,
  input wire logic frame_request,
  input wire logic upload_valid,
  input wire logic [6:0] upload_addr,
  input wire logic [7:0] upload_data,
  input wire logic dev_exposing,
  input wire logic dev_fot,
  input wire logic dev_readout,
  input wire logic dev_busy,
  input wire logic frame_done
);
  logic [15:0] lines_reg;
  logic [2:0] code_reg;
  logic [7:0] fot_reg;
  logic m12_reg;
  logic [8:0] post_reg;
  logic [31:0] fot_cnt_reg;
  logic [31:0] ro_cnt_reg;
  int line_cyc;
  int fot_exp;
  int ro_exp;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  assign line_cyc = 129 * (16 >> code_reg);
  assign fot_exp = (int'(fot_reg) + (32 >> code_reg)) * 129;
  // 12-bit stretch applies per line, rounded down
  assign ro_exp = int'(lines_reg) * (m12_reg ? line_cyc * 12 / 10 : line_cyc);
  // Shadow of the timing settings, cleared with the sensor
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !system_reset_low)
    begin
      lines_reg <= RST_LINES;
      code_reg <= RST_OUT_CODE;
      fot_reg <= RST_FOT_LEN;
      m12_reg <= 1'b0;
    end
    else if (upload_valid)
    begin
      if (upload_addr == ADR_LINES_LO) lines_reg[7:0] <= upload_data;
      if (upload_addr == ADR_LINES_HI) lines_reg[15:8] <= upload_data;
      if (upload_addr == ADR_OUT_CODE && upload_data <= 8'h04) code_reg <= upload_data[2:0];
      if (upload_addr == ADR_FOT_LEN) fot_reg <= upload_data;
      if (upload_addr == ADR_BIT_MODE) m12_reg <= upload_data[0];
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !system_reset_low)
      post_reg <= 9'h000;
    else if (post_reg != 9'h1ff)
      post_reg <= post_reg + 9'h001;
    fot_cnt_reg <= dev_fot ? fot_cnt_reg + 32'h1 : 32'h0;
    ro_cnt_reg <= dev_readout ? ro_cnt_reg + 32'h1 : 32'h0;
  end
  chk_ratio_legal: assert property (
    master_clk_run |-> (bit_clk_ratio == RATIO_10BIT || bit_clk_ratio == RATIO_12BIT))
    else $error("bit clock ratio illegal");
  chk_clk_before_release: assert property (
    $rose(system_reset_low) |-> master_clk_run)
    else $error("reset released without master clock");
  chk_req_after_release: assert property (
    frame_request |-> post_reg >= 9'h0c8)
    else $error("frame request too soon after release");
  chk_no_req_reset: assert property (
    !system_reset_low |-> !frame_request)
    else $error("frame request during sensor reset");
  chk_no_req_upload: assert property (
    upload_valid |-> !frame_request)
    else $error("frame request during upload");
  chk_req_one_pulse: assert property (
    frame_request |=> !frame_request)
    else $error("frame request longer than one cycle");
  chk_busy_answer: assert property (
    frame_request && !dev_busy |-> ##3 (dev_busy && dev_exposing))
    else $error("idle sensor did not start exposure");
  chk_seq_reset: assert property (
    !system_reset_low [*4] |-> !dev_busy && !dev_fot && !dev_readout)
    else $error("sequencer active during sensor reset");
  chk_expose_to_fot: assert property (
    $fell(dev_exposing) && !dev_readout && system_reset_low |=> dev_fot)
    else $error("overhead did not follow exposure");
  chk_fot_length: assert property (
    $fell(dev_fot) && system_reset_low |-> fot_cnt_reg == fot_exp)
    else $error("overhead length wrong");
  chk_fot_to_readout: assert property (
    $fell(dev_fot) && system_reset_low |-> dev_readout)
    else $error("read-out did not follow overhead");
  chk_readout_length: assert property (
    $fell(dev_readout) && system_reset_low |-> ro_cnt_reg == ro_exp)
    else $error("read-out length wrong");
  cov_frame_done: cover property (frame_done);
  cov_overlap: cover property (dev_exposing && dev_readout);
  cov_upload: cover property (upload_valid);
endmodule

// file: test/sensor_startup_frame_timing_tb.sv
`timescale 1ns/1ps
module sensor_startup_frame_timing_tb
  import ssft_pkg::*;
;
  logic sys_clk;
  logic rst_n;
  logic supplies_ok;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [7:0] gain_setting;
  logic [7:0] fot_length;
  logic bit_mode_12;
  logic [15:0] frames_sent;
  logic [31:0] frame_period_cyc;
  logic [15:0] d;
  int num_errors;
  int n_tests;
  int cyc;
  ssft_link_if i_ssft_link_if ();
  ssft_controller #(.SETTLE_TYP(50), .SETTLE_MAX(100)) i_ssft_controller (
    .sys_clk(sys_clk), .rst_n(rst_n), .supplies_ok(supplies_ok), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(i_ssft_link_if.ctl));
  ssft_sensor i_ssft_sensor (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(i_ssft_link_if.dev), .gain_setting(gain_setting),
    .fot_length(fot_length), .bit_mode_12(bit_mode_12), .frames_sent(frames_sent),
    .frame_period_cyc(frame_period_cyc));
  ssft_monitor i_ssft_monitor (
    .sys_clk(sys_clk), .rst_n(rst_n), .master_clk_run(i_ssft_link_if.master_clk_run),
    .bit_clk_ratio(i_ssft_link_if.bit_clk_ratio),
    .system_reset_low(i_ssft_link_if.system_reset_low),
    .frame_request(i_ssft_link_if.frame_request), .upload_valid(i_ssft_link_if.upload_valid),
    .upload_addr(i_ssft_link_if.upload_addr), .upload_data(i_ssft_link_if.upload_data),
    .dev_exposing(i_ssft_link_if.dev_exposing), .dev_fot(i_ssft_link_if.dev_fot),
    .dev_readout(i_ssft_link_if.dev_readout), .dev_busy(i_ssft_link_if.dev_busy),
    .frame_done(i_ssft_link_if.frame_done));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic results;
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic up(input logic [6:0] a, input logic [7:0] v);
    wr(CREG_UPLOAD, {1'b0, a, v});
  endtask
  // Polls the phase field; two cycles per poll
  task automatic wait_phase(input logic [2:0] ph);
    cyc = 0;
    rd(CREG_STATUS, d);
    while (d[2:0] !== ph)
    begin
      cyc += 2;
      if (cyc > 3000)
      begin
        chk("phase", ph, d[2:0]);
        results();
      end
      rd(CREG_STATUS, d);
    end
  endtask
  task automatic wait_frames(input logic [15:0] n);
    for (int i = 0; i < 40000 && frames_sent !== n; i++) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    #1;
    if (frames_sent !== n)
    begin
      chk("frames_sent", n, frames_sent);
      results();
    end
  endtask
  // Ten lines, two frames, overhead length 3
  task automatic load(input logic [7:0] elo, input logic [7:0] emid, input logic [7:0] code,
    input logic [7:0] mode);
    up(ADR_LINES_LO, 8'h0a);
    up(ADR_LINES_HI, 8'h00);
    up(ADR_EXP_LO, elo);
    up(ADR_EXP_MID, emid);
    up(ADR_EXP_HI, 8'h00);
    up(ADR_FRAMES_LO, 8'h02);
    up(ADR_FRAMES_HI, 8'h00);
    up(ADR_OUT_CODE, code);
    up(ADR_FOT_LEN, 8'h03);
    up(ADR_BIT_MODE, mode);
    up(ADR_GAIN, 8'h2c);
  endtask
  initial
  begin
    rst_n = 1'b0;
    supplies_ok = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk("gain_setting", 32'h20, gain_setting);
    chk("fot_length", 32'h0a, fot_length);
    chk("system_reset_low", 32'h0, i_ssft_link_if.system_reset_low);
    wr(CREG_FRAME, 16'h0000);
    rd(CREG_STATUS, d);
    chk("refused_off", 32'h1, d[STAT_REFUSED]);
    rd(4'hf, d);
    chk("unmapped", 32'h0, d);
    wr(CREG_CTRL, 16'h0001);
    rd(CREG_CTRL, d);
    chk("ctrl", 32'h1, d[2:0]);
    @(posedge sys_clk);
    supplies_ok <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 chk("master_clk_run", 32'h1, i_ssft_link_if.master_clk_run);
    chk("held_low", 32'h0, i_ssft_link_if.system_reset_low);
    wait_phase(3'h3);
    chk("release_time", 32'h1, cyc + 22 >= 400);
    chk("ratio10", RATIO_10BIT, i_ssft_link_if.bit_clk_ratio);
    load(8'h20, 8'h00, 8'h04, 8'h00);
    wr(CREG_CTRL, 16'h0009);
    wr(CREG_FRAME, 16'h0000);
    rd(CREG_STATUS, d);
    chk("refused_settle", 32'h1, d[STAT_REFUSED]);
    wait_phase(3'h5);
    chk("settle_typ", 32'h1, cyc + 6 >= 50);
    chk("gain_loaded", 32'h2c, gain_setting);
    chk("fot_loaded", 32'h03, fot_length);
    wr(CREG_FRAME, 16'h0000);
    rd(CREG_STATUS, d);
    rd(CREG_STATUS, d);
    chk("busy", 32'h1, d[STAT_BUSY]);
    chk("ready", 32'h1, d[STAT_READY]);
    wait_frames(16'h0002);
    chk("period_short", 32'h0000078f, frame_period_cyc);
    wr(CREG_CTRL, 16'h0017);
    wait_phase(3'h3);
    chk("gain_reset", 32'h20, gain_setting);
    chk("frames_reset", 32'h0, frames_sent);
    chk("ratio12", RATIO_12BIT, i_ssft_link_if.bit_clk_ratio);
    load(8'h40, 8'h1f, 8'h02, 8'h01);
    wr(CREG_CTRL, 16'h000f);
    wait_phase(3'h5);
    chk("settle_max", 32'h1, cyc + 6 >= 100);
    chk("bit_mode_12", 32'h1, bit_mode_12);
    wr(CREG_FRAME, 16'h0000);
    wait_frames(16'h0002);
    // Rest of the exposure, one hand-over cycle, then overhead and read-out in turn
    chk("period_long", 32'h000024cc, frame_period_cyc);
    results();
  end
endmodule
